// ==== phx_ext_page1.v ====
// Purpose: extended page 1 control and status bank behind the management serial port
// Assumes: mdc_in, mdio_in and low_power_hold_input are pins, sampled by clk_in; other inputs share clk_in
// Notes: preamble of 32 ones required before each frame
// Contract
// RL1: master selects page 1 by writing 0x0001 to register 31; 0x0000 restores.
// RL2: counter bit 15 flags a copper packet since last read, cleared by read.
// RL3: good-CRC count is 14 bits modulo 10,000, wrapping to zero after 9,999.
// RL4: good-CRC count clears when read, returning packets since previous read.
// RL5: bits 15 to 12 put LEDs 3 to 0 into basic serial mode.
// RL6: bit 11 set blinks LEDs after low-power hold release; cleared suppresses.
// RL7: bit 4 enables fast link failure pin; program it only via port 0.
// RL8: crossover field 00 auto, 01 reserved, 10 forced MDI, 11 forced MDI-X.
// RL9: power-save bit 15, reset one, disables gigabit carrier extension.
// RL10: sleep timer codes give 1, 2, 3 or 4 seconds; reset code 01.
// RL11: wake timer codes give 160, 400, 800 ms or 2 s; reset 00.
// RL12: software sets slow clock bit when management clock is below 10 MHz.
// RL13: bit 9 swaps port 0 and 1 addresses; lives on port 0 only.
// RL14: media status reads 00 with no media, 01 with copper selected.
// RL15: bit 5 lets 10BASE-T assert receive valid without a preamble.
// RL16: power-save bit 4 enables speed downshift after gigabit negotiation failures.
// RL17: downshift after 2, 3, 4 or 5 failures per code; reset code 01.
// RL18: sticky bits survive soft reset; only hardware reset restores them.
`timescale 1ns/1ps
`default_nettype none
`include "phx_map.vh"

module phx_ext_page1 #(
	parameter PORT_ID = 1'b0,
	parameter [4:0] PHY_BASE_ADDR = 5'h00,
	parameter MS_CYCLES = `PHX_MS_NS / `PHX_CLK_NS,
	parameter [11:0] BLINK_MS = `PHX_BLINK_MS
) (
	// clock and resets
	input wire clk_in,
	input wire rst_in,
	input wire soft_reset_in,
	// management serial port
	input wire mdc_in,
	input wire mdio_in,
	output reg mdio_out,
	output reg mdio_oe_out,
	// port pairing
	input wire addr_swap_in,
	output wire addr_swap_out,
	// status from the port
	input wire good_crc_pkt_in,
	input wire copper_media_in,
	input wire low_power_hold_input,
	input wire link_sleep_en_in,
	input wire link_energy_in,
	input wire gig_an_fail_in,
	input wire link_up_in,
	// controls to the port
	output wire [3:0] led_serial_mode_out,
	output wire led_blink_out,
	output wire fast_link_fail_en_out,
	output wire auto_mdix_out,
	output wire force_mdi_out,
	output wire force_mdix_out,
	output wire carrier_ext_disable_out,
	output wire slow_mgmt_clk_out,
	output wire no_preamble_en_out,
	output reg link_sleep_out,
	output reg wake_pulse_out,
	output reg downshift_out
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_HDR = 3'h1;
	localparam [2:0] ST_TA = 3'h2;
	localparam [2:0] ST_RDATA = 3'h3;
	localparam [2:0] ST_WDATA = 3'h4;

	wire mdc_s;
	wire mdio_s;
	wire hold_s;
	wire ms_tick;
	reg mdc_d;
	reg hold_d;
	reg [2:0] state;
	reg [5:0] pre_cnt;
	reg [4:0] bit_cnt;
	reg [11:0] hdr;
	reg op_rd;
	reg [4:0] reg_addr;
	reg [15:0] shreg;
	reg [15:0] page;
	// good-CRC counter
	reg pkt_seen;
	reg [13:0] crc_cnt;
	// extended mode control fields
	reg [3:0] led_ext;
	reg blink_en;
	reg fast_fail;
	reg [1:0] mdix;
	reg rsvd0;
	// power-save and downshift fields
	reg carr_dis;
	reg [1:0] sleep_sel;
	reg [1:0] wake_sel;
	reg slow_mdc;
	reg addr_swap;
	reg nopre;
	reg ds_en;
	reg [1:0] ds_sel;
	// timers
	reg [11:0] ms_cnt;
	reg [11:0] blink_cnt;
	reg [2:0] fail_cnt;

	// ****************************************************************
	// decode helpers
	// ****************************************************************
	// true when the address lands on a page 1 register of this bank
	function is_page1;
		input [4:0] a;
		input [15:0] pg;
		input [4:0] which;
		begin
			is_page1 = (pg == `PHX_PAGE_EXT1) && (a == which);
		end
	endfunction

	// millisecond figure for a sleep or wake timer code
	function [11:0] timer_ms;
		input sleep;
		input [1:0] code;
		begin
			case ({sleep, code})
				3'h4: timer_ms = `PHX_SLEEP_MS_0;
				3'h5: timer_ms = `PHX_SLEEP_MS_1;
				3'h6: timer_ms = `PHX_SLEEP_MS_2;
				3'h7: timer_ms = `PHX_SLEEP_MS_3;
				3'h0: timer_ms = `PHX_WAKE_MS_0;
				3'h1: timer_ms = `PHX_WAKE_MS_1;
				3'h2: timer_ms = `PHX_WAKE_MS_2;
				default: timer_ms = `PHX_WAKE_MS_3;
			endcase
		end
	endfunction

	// ****************************************************************
	// pin sampling and time base
	// ****************************************************************
	// mdc, mdio and the hold pin cross into clk_in here
	phx_sync #(
		.WIDTH(3)
	) u_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.d_in({mdc_in, mdio_in, low_power_hold_input}),
		.q_out({mdc_s, mdio_s, hold_s})
	);

	phx_ms_tick #(
		.CYCLES(MS_CYCLES),
		.CNT_W(16)
	) u_tick (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.tick_out(ms_tick)
	);

	// edge history of synchronised pins
	always @(posedge clk_in) begin
		if (rst_in) begin
			mdc_d <= 1'b0;
			hold_d <= 1'b0;
		end else begin
			mdc_d <= mdc_s;
			hold_d <= hold_s;
		end
	end

	wire mdc_rise = mdc_s & ~mdc_d;
	wire hold_fall = hold_d & ~hold_s;

	// ****************************************************************
	// addressing
	// ****************************************************************
	// port 1 follows the swap held in port 0
	wire swap_eff = (PORT_ID == 1'b0) ? addr_swap : addr_swap_in; // see RL13
	wire [4:0] my_addr = {PHY_BASE_ADDR[4:1], PORT_ID[0] ^ swap_eff};
	wire [12:0] hdr_full = {hdr, mdio_s};
	wire hdr_ok = hdr_full[12] && (hdr_full[9:5] == my_addr) &&
		((hdr_full[11:10] == `PHX_OP_READ) || (hdr_full[11:10] == `PHX_OP_WRITE));

	// ****************************************************************
	// read data and side effects
	// ****************************************************************
	wire [1:0] media = copper_media_in ? `PHX_MEDIA_CU : `PHX_MEDIA_NONE; // see RL14
	wire swap_rd = (PORT_ID == 1'b0) ? addr_swap : 1'b0;
	reg [15:0] rdata;

	// unmapped addresses answer zero so the master never reads a floating line
	always @* begin
		if (reg_addr == `PHX_REG_PAGE) begin
			rdata = page;
		end else if (is_page1(reg_addr, page, `PHX_REG_GOOD_CRC)) begin
			rdata = {pkt_seen, 1'b0, crc_cnt};
		end else if (is_page1(reg_addr, page, `PHX_REG_EXT_MODE)) begin
			rdata = {led_ext, blink_en, 6'h00, fast_fail, mdix, 1'b0, rsvd0};
		end else if (is_page1(reg_addr, page, `PHX_REG_PWR_SAVE)) begin
			rdata = {carr_dis, sleep_sel, wake_sel, slow_mdc, swap_rd, 1'b0,
				media, nopre, ds_en, ds_sel, 2'h0};
		end else begin
			rdata = 16'h0000;
		end
	end

	// the counter is latched and cleared on the same edge, so no packet slips
	wire rd_clear = mdc_rise && (state == ST_TA) && op_rd &&
		is_page1(reg_addr, page, `PHX_REG_GOOD_CRC); // see RL4
	wire wr_commit = mdc_rise && (state == ST_WDATA) && (bit_cnt == `PHX_DATA_LAST);
	wire [15:0] wr_data = {shreg[14:0], mdio_s};

	// ****************************************************************
	// management frame engine
	// ****************************************************************
	// bits are taken on mdc rising edges; read bits change just after them
	always @(posedge clk_in) begin
		if (rst_in) begin
			state <= ST_IDLE;
			pre_cnt <= 6'h00;
			bit_cnt <= 5'h00;
			hdr <= 12'h000;
			op_rd <= 1'b0;
			reg_addr <= 5'h00;
			shreg <= 16'h0000;
			mdio_out <= 1'b0;
			mdio_oe_out <= 1'b0;
		end else if (mdc_rise) begin
			case (state)
				ST_IDLE: begin
					bit_cnt <= 5'h00;
					if (mdio_s) begin
						if (pre_cnt != `PHX_PRE_LEN) begin
							pre_cnt <= pre_cnt + 1'b1;
						end
					end else if (pre_cnt == `PHX_PRE_LEN) begin
						pre_cnt <= 6'h00;
						state <= ST_HDR;
					end else begin
						pre_cnt <= 6'h00;
					end
				end
				ST_HDR: begin
					hdr <= hdr_full[11:0];
					bit_cnt <= bit_cnt + 1'b1;
					if (bit_cnt == {1'b0, `PHX_HDR_LAST}) begin
						op_rd <= (hdr_full[11:10] == `PHX_OP_READ);
						reg_addr <= hdr_full[4:0];
						state <= hdr_ok ? ST_TA : ST_IDLE;
					end
				end
				ST_TA: begin
					bit_cnt <= 5'h00;
					if (op_rd) begin
						// drive the second turnaround bit low
						mdio_oe_out <= 1'b1;
						mdio_out <= 1'b0;
						shreg <= rdata;
						state <= ST_RDATA;
					end else begin
						shreg <= 16'h0000;
						state <= ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (bit_cnt == `PHX_DATA_LAST) begin
						mdio_oe_out <= 1'b0;
						mdio_out <= 1'b0;
						state <= ST_IDLE;
					end else begin
						mdio_out <= shreg[15];
						shreg <= {shreg[14:0], 1'b0};
						bit_cnt <= bit_cnt + 1'b1;
					end
				end
				ST_WDATA: begin
					// the second turnaround bit shifts out of the top
					shreg <= wr_data;
					bit_cnt <= bit_cnt + 1'b1;
					if (bit_cnt == `PHX_DATA_LAST) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// page select and control fields
	// ****************************************************************
	// soft reset restores only the non-sticky bits and the page
	always @(posedge clk_in) begin
		if (rst_in) begin
			page <= `PHX_PAGE_MAIN;
			led_ext <= 4'h0;
			blink_en <= 1'b0;
			fast_fail <= 1'b0;
			mdix <= `PHX_MDIX_AUTO;
			rsvd0 <= 1'b0;
			carr_dis <= `PHX_RST_CARR_DIS;
			sleep_sel <= `PHX_RST_SLEEP;
			wake_sel <= `PHX_RST_WAKE;
			slow_mdc <= 1'b0;
			addr_swap <= 1'b0;
			nopre <= 1'b0;
			ds_en <= 1'b0;
			ds_sel <= `PHX_RST_DS_CNT;
		end else if (soft_reset_in) begin
			page <= `PHX_PAGE_MAIN; // see RL18
			carr_dis <= `PHX_RST_CARR_DIS; // see RL18
		end else if (wr_commit) begin
			if (reg_addr == `PHX_REG_PAGE) begin
				page <= wr_data; // see RL1
			end else if (is_page1(reg_addr, page, `PHX_REG_EXT_MODE)) begin
				led_ext <= wr_data[`PHX_F_LED_EXT];
				blink_en <= wr_data[`PHX_F_BLINK];
				fast_fail <= wr_data[`PHX_F_FAST_FAIL];
				mdix <= wr_data[`PHX_F_MDIX];
				rsvd0 <= wr_data[`PHX_F_RSVD0];
			end else if (is_page1(reg_addr, page, `PHX_REG_PWR_SAVE)) begin
				carr_dis <= wr_data[`PHX_F_CARR_DIS];
				sleep_sel <= wr_data[`PHX_F_SLEEP];
				wake_sel <= wr_data[`PHX_F_WAKE];
				slow_mdc <= wr_data[`PHX_F_SLOW_MDC];
				// only port 0 holds the swap bit
				if (PORT_ID == 1'b0) begin
					addr_swap <= wr_data[`PHX_F_SWAP]; // see RL13
				end
				nopre <= wr_data[`PHX_F_NOPRE];
				ds_en <= wr_data[`PHX_F_DS_EN];
				ds_sel <= wr_data[`PHX_F_DS_CNT];
			end
		end
	end

	// ****************************************************************
	// good-CRC packet counter
	// ****************************************************************
	// a packet in the clearing cycle counts as the first of the next read
	always @(posedge clk_in) begin
		if (rst_in || soft_reset_in) begin
			pkt_seen <= 1'b0;
			crc_cnt <= 14'h0000;
		end else if (rd_clear) begin
			pkt_seen <= good_crc_pkt_in; // see RL2
			crc_cnt <= good_crc_pkt_in ? 14'h0001 : 14'h0000; // see RL4
		end else if (good_crc_pkt_in) begin
			pkt_seen <= 1'b1; // see RL2
			crc_cnt <= (crc_cnt == `PHX_CRC_LAST) ? 14'h0000 : crc_cnt + 1'b1; // see RL3
		end
	end

	// ****************************************************************
	// mode outputs
	// ****************************************************************
	assign led_serial_mode_out = led_ext; // see RL5
	assign fast_link_fail_en_out = (PORT_ID == 1'b0) & fast_fail; // see RL7
	// reserved crossover code falls back to automatic detection
	assign force_mdi_out = (mdix == `PHX_MDIX_MDI); // see RL8
	assign force_mdix_out = (mdix == `PHX_MDIX_MDIX); // see RL8
	assign auto_mdix_out = ~force_mdi_out & ~force_mdix_out; // see RL8
	assign carrier_ext_disable_out = carr_dis; // see RL9
	assign slow_mgmt_clk_out = slow_mdc; // see RL12
	assign no_preamble_en_out = nopre; // see RL15
	assign addr_swap_out = swap_eff;
	assign led_blink_out = (blink_cnt != 12'h000);

	// ****************************************************************
	// blink window after the hold is released
	// ****************************************************************
	always @(posedge clk_in) begin
		if (rst_in) begin
			blink_cnt <= 12'h000;
		end else if (hold_fall) begin
			blink_cnt <= blink_en ? BLINK_MS : 12'h000; // see RL6
		end else if (ms_tick && (blink_cnt != 12'h000)) begin
			blink_cnt <= blink_cnt - 1'b1;
		end
	end

	// ****************************************************************
	// link sleep power save timers
	// ****************************************************************
	// energy restarts the idle count; while asleep a wake probe fires periodically
	always @(posedge clk_in) begin
		if (rst_in || !link_sleep_en_in || link_energy_in) begin
			link_sleep_out <= 1'b0;
			wake_pulse_out <= 1'b0;
			ms_cnt <= 12'h000;
		end else begin
			wake_pulse_out <= 1'b0;
			if (ms_tick) begin
				if (!link_sleep_out) begin
					if (ms_cnt + 1'b1 >= timer_ms(1'b1, sleep_sel)) begin // see RL10
						link_sleep_out <= 1'b1;
						ms_cnt <= 12'h000;
					end else begin
						ms_cnt <= ms_cnt + 1'b1;
					end
				end else if (ms_cnt + 1'b1 >= timer_ms(1'b0, wake_sel)) begin // see RL11
					wake_pulse_out <= 1'b1;
					ms_cnt <= 12'h000;
				end else begin
					ms_cnt <= ms_cnt + 1'b1;
				end
			end
		end
	end

	// ****************************************************************
	// speed downshift
	// ****************************************************************
	// a successful link forgets earlier failures but keeps the downshift
	wire [2:0] ds_limit = {1'b0, ds_sel} + `PHX_DS_BASE; // see RL17
	always @(posedge clk_in) begin
		if (rst_in || soft_reset_in || !ds_en) begin
			fail_cnt <= 3'h0;
			downshift_out <= 1'b0;
		end else if (link_up_in) begin
			fail_cnt <= 3'h0;
		end else if (gig_an_fail_in && !downshift_out) begin
			fail_cnt <= fail_cnt + 1'b1;
			if (fail_cnt + 1'b1 >= ds_limit) begin
				downshift_out <= 1'b1; // see RL16
			end
		end
	end

endmodule
`default_nettype wire

// ==== phx_map.vh ====
// Purpose: constants for the extended page 1 control and status bank
// Assumes: included by bare name from the bank design file only
// Notes: definitions only
`ifndef PHX_MAP_VH
`define PHX_MAP_VH

// ****************************************************************
// management frame
// ****************************************************************
`define PHX_PRE_LEN 6'h20
`define PHX_HDR_LAST 4'hC
`define PHX_DATA_LAST 5'h10
`define PHX_OP_READ 2'h2
`define PHX_OP_WRITE 2'h1

// ****************************************************************
// register addresses and page codes
// ****************************************************************
`define PHX_REG_PAGE 5'h1F
`define PHX_REG_GOOD_CRC 5'h12
`define PHX_REG_EXT_MODE 5'h13
`define PHX_REG_PWR_SAVE 5'h14
`define PHX_PAGE_MAIN 16'h0000
`define PHX_PAGE_EXT1 16'h0001

// ****************************************************************
// field layouts
// ****************************************************************
`define PHX_F_LED_EXT 15:12
`define PHX_F_BLINK 11
`define PHX_F_FAST_FAIL 4
`define PHX_F_MDIX 3:2
`define PHX_F_RSVD0 0
`define PHX_F_CARR_DIS 15
`define PHX_F_SLEEP 14:13
`define PHX_F_WAKE 12:11
`define PHX_F_SLOW_MDC 10
`define PHX_F_SWAP 9
`define PHX_F_NOPRE 5
`define PHX_F_DS_EN 4
`define PHX_F_DS_CNT 3:2

// ****************************************************************
// reset values and encodings
// ****************************************************************
`define PHX_RST_CARR_DIS 1'h1
`define PHX_RST_SLEEP 2'h1
`define PHX_RST_WAKE 2'h0
`define PHX_RST_DS_CNT 2'h1
`define PHX_MDIX_AUTO 2'h0
`define PHX_MDIX_MDI 2'h2
`define PHX_MDIX_MDIX 2'h3
`define PHX_MEDIA_NONE 2'h0
`define PHX_MEDIA_CU 2'h1
`define PHX_CRC_LAST 14'h270F
`define PHX_DS_BASE 3'h2

// ****************************************************************
// timing
// ****************************************************************
`define PHX_CLK_NS 40
`define PHX_MS_NS 1000000
`define PHX_SLEEP_MS_0 12'h3E8
`define PHX_SLEEP_MS_1 12'h7D0
`define PHX_SLEEP_MS_2 12'hBB8
`define PHX_SLEEP_MS_3 12'hFA0
`define PHX_WAKE_MS_0 12'h0A0
`define PHX_WAKE_MS_1 12'h190
`define PHX_WAKE_MS_2 12'h320
`define PHX_WAKE_MS_3 12'h7D0
`define PHX_BLINK_MS 12'h1F4

`endif

// ==== phx_sync.v ====
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk_in
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module phx_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input wire clk_in,
	input wire rst_in,
	// data
	input wire [WIDTH-1:0] d_in,
	output reg [WIDTH-1:0] q_out
);

	reg [WIDTH-1:0] meta;

	// ****************************************************************
	// two stages
	// ****************************************************************
	// metastability stage then output stage
	always @(posedge clk_in) begin
		if (rst_in) begin
			meta <= {WIDTH{1'b0}};
			q_out <= {WIDTH{1'b0}};
		end else begin
			meta <= d_in;
			q_out <= meta;
		end
	end

endmodule
`default_nettype wire

// ==== phx_ms_tick.v ====
// Purpose: one-cycle enable pulse every millisecond
// Assumes: CYCLES is the clock count per millisecond
// Notes: free running from reset
`timescale 1ns/1ps
`default_nettype none

module phx_ms_tick #(
	parameter CYCLES = 25000,
	parameter CNT_W = 16
) (
	// clock and reset
	input wire clk_in,
	input wire rst_in,
	// enable pulse
	output reg tick_out
);

	// full-width figure first, then cut to the counter on purpose
	localparam [31:0] LAST_W = CYCLES - 1;
	localparam [CNT_W-1:0] LAST = LAST_W[CNT_W-1:0];
	reg [CNT_W-1:0] cnt;

	// ****************************************************************
	// divider
	// ****************************************************************
	// wrap at the last count and strobe once
	always @(posedge clk_in) begin
		if (rst_in) begin
			cnt <= {CNT_W{1'b0}};
			tick_out <= 1'b0;
		end else if (cnt == LAST) begin
			cnt <= {CNT_W{1'b0}};
			tick_out <= 1'b1;
		end else begin
			cnt <= cnt + 1'b1;
			tick_out <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ==== phx_mgmt_master.sv ====
// Purpose: management master model driving mdc and mdio
// Assumes: mdio has a pull-up; one bit is 8 clk_in cycles
// Notes: mdc stands low between frames
`timescale 1ns/1ps
`default_nettype none
// ****
// master model
// ****
module phx_mgmt_master (
	// clock
	input wire logic clk_in,
	// device drive
	input wire logic dev_oe_in,
	input wire logic dev_dat_in,
	// pins
	output var logic mdc_out,
	output wire logic mdio_out
);
	logic drv_en = 1'b0;
	logic drv_val = 1'b0;
	logic smp = 1'b0;
	// a released line floats up through the pull-up
	assign mdio_out = dev_oe_in ? dev_dat_in : (drv_en ? drv_val : 1'b1);
	initial mdc_out = 1'b0;
	// one bit: data set up in the low half, sampled just before the rise
	task automatic slot(input logic en, input logic v);
		drv_en <= en;
		drv_val <= v;
		mdc_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		smp = mdio_out;
		mdc_out <= 1'b1;
		repeat (4) @(posedge clk_in);
	endtask
	// whole frame; full preamble every time since the device needs it
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [45:0] hdr;
		logic wr;
		hdr = {32'hFFFFFFFF, 2'h1, op, phy, ra};
		wr = (op == 2'h1);
		@(posedge clk_in);
		for (int i = 45; i >= 0; i--)
			slot(1'b1, hdr[i]);
		slot(wr, 1'b1);
		slot(wr, 1'b0);
		for (int i = 15; i >= 0; i--) begin
			slot(wr, wd[i]);
			rd[i] = smp;
		end
		drv_en <= 1'b0;
		mdc_out <= 1'b0;
		repeat (16) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// ==== phx_ext_page1_chk.sv ====
// Purpose: port assertions for the page 1 bank
// Assumes: single clk_in domain, synchronous rst_in
// Notes: bound into every bank instance
`timescale 1ns/1ps
`default_nettype none
// ****
// checker
// ****
module phx_ext_page1_chk (
	// clock and resets
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic soft_reset_in,
	// inputs
	input wire logic mdc_in,
	input wire logic link_energy_in,
	input wire logic gig_an_fail_in,
	// outputs
	input wire logic mdio_oe_out,
	input wire logic [3:0] led_serial_mode_out,
	input wire logic fast_link_fail_en_out,
	input wire logic auto_mdix_out,
	input wire logic force_mdi_out,
	input wire logic force_mdix_out,
	input wire logic carrier_ext_disable_out,
	input wire logic link_sleep_out,
	input wire logic wake_pulse_out,
	input wire logic downshift_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// writes land a few cycles after a synchronised mdc rise
	sequence s_mdc_recent;
		$past(mdc_in, 2) || $past(mdc_in, 3) || $past(mdc_in, 4) || $past(mdc_in, 5);
	endsequence
	a_rst_defaults: assert property (disable iff (1'b0)
		rst_in |=> carrier_ext_disable_out && auto_mdix_out && !mdio_oe_out
		&& !downshift_out && led_serial_mode_out == 4'h0) else $error("reset values");
	a_mdix_onehot: assert property (
		$onehot({auto_mdix_out, force_mdi_out, force_mdix_out})) else $error("mdix decode");
	a_ctrl_on_mdc: assert property (
		$changed({led_serial_mode_out, force_mdi_out, force_mdix_out, fast_link_fail_en_out})
		|-> s_mdc_recent) else $error("control moved without write");
	a_soft_carrier: assert property (
		soft_reset_in |=> carrier_ext_disable_out) else $error("carrier bit kept");
	a_soft_sticky: assert property (
		soft_reset_in |=> $stable({led_serial_mode_out, force_mdix_out, fast_link_fail_en_out}))
		else $error("sticky bit lost");
	a_ds_cause: assert property (
		$rose(downshift_out) |-> $past(gig_an_fail_in)) else $error("downshift uncaused");
	a_energy_wakes: assert property (
		link_energy_in |=> !link_sleep_out && !wake_pulse_out) else $error("sleep with energy");
	a_wake_single: assert property (
		wake_pulse_out |-> $past(link_sleep_out) ##1 !wake_pulse_out) else $error("wake pulse");
endmodule
bind phx_ext_page1 phx_ext_page1_chk u_chk (.clk_in, .rst_in, .soft_reset_in, .mdc_in,
	.link_energy_in, .gig_an_fail_in, .mdio_oe_out, .led_serial_mode_out,
	.fast_link_fail_en_out, .auto_mdix_out, .force_mdi_out, .force_mdix_out,
	.carrier_ext_disable_out, .link_sleep_out, .wake_pulse_out, .downshift_out);
`default_nettype wire

// ==== tb_phx_ext_page1.sv ====
// Purpose: self-checking bench for the page 1 bank
// Assumes: master model owns mdc and mdio
// Notes: millisecond tick shortened to 10 cycles
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module tb_phx_ext_page1;
	localparam int MS = 10;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic soft_reset_in = 1'b0;
	logic good_crc_pkt_in = 1'b0;
	logic copper_media_in = 1'b0;
	logic low_power_hold_input = 1'b0;
	logic link_sleep_en_in = 1'b1;
	logic link_energy_in = 1'b1;
	logic gig_an_fail_in = 1'b0;
	logic link_up_in = 1'b0;
	logic [4:0] phy = 5'h00;
	int failures = 0;
	int comparisons = 0;
	wire logic mdc_in, mdio_in, mdio_out, mdio_oe_out, addr_swap_out, led_blink_out;
	wire logic fast_link_fail_en_out, auto_mdix_out, force_mdi_out, force_mdix_out;
	wire logic carrier_ext_disable_out, slow_mgmt_clk_out, no_preamble_en_out;
	wire logic link_sleep_out, wake_pulse_out, downshift_out;
	wire logic [3:0] led_serial_mode_out;
	wire logic [2:0] flags = {led_blink_out, wake_pulse_out, link_sleep_out};
	always #20 clk_in = ~clk_in;
	phx_mgmt_master mst (.clk_in, .dev_oe_in(mdio_oe_out), .dev_dat_in(mdio_out),
		.mdc_out(mdc_in), .mdio_out(mdio_in));
	phx_ext_page1 #(.MS_CYCLES(MS), .BLINK_MS(12'h002)) uut (.clk_in, .rst_in, .soft_reset_in,
		.mdc_in, .mdio_in, .mdio_out, .mdio_oe_out, .addr_swap_in(1'b0), .addr_swap_out,
		.good_crc_pkt_in, .copper_media_in, .low_power_hold_input, .link_sleep_en_in,
		.link_energy_in, .gig_an_fail_in, .link_up_in, .led_serial_mode_out, .led_blink_out,
		.fast_link_fail_en_out, .auto_mdix_out, .force_mdi_out, .force_mdix_out,
		.carrier_ext_disable_out, .slow_mgmt_clk_out, .no_preamble_en_out, .link_sleep_out,
		.wake_pulse_out, .downshift_out);
	// verdict and shared helpers
	task automatic summarize();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] r;
		mst.frame(2'h1, phy, a, d, r);
	endtask
	task automatic rdc(input logic [4:0] a, input logic [15:0] e);
		logic [15:0] r;
		mst.frame(2'h2, phy, a, 16'h0000, r);
		chk(r, e);
	endtask
	// one-cycle pulses, spaced so each is seen alone
	task automatic pulses(input int n, input logic crc);
		repeat (n) begin
			@(posedge clk_in);
			good_crc_pkt_in <= crc;
			gig_an_fail_in <= !crc;
			@(posedge clk_in);
			good_crc_pkt_in <= 1'b0;
			gig_an_fail_in <= 1'b0;
		end
		@(posedge clk_in);
	endtask
	// bounded wait on one status flag
	task automatic waitsig(input int sel, input int lim, output int n);
		n = 0;
		while (flags[sel] !== 1'b1 && n < lim) begin
			@(posedge clk_in);
			n++;
		end
	endtask
	// page select, foreign address, reset values, media
	task automatic t_page();
		logic [15:0] r;
		rdc(5'h14, 16'h0000);
		mst.frame(2'h2, 5'h03, 5'h14, 16'h0000, r);
		chk(r, 16'hFFFF);
		wr(5'h1F, 16'h0001);
		rdc(5'h14, 16'hA004);
		rdc(5'h13, 16'h0000);
		copper_media_in <= 1'b1;
		rdc(5'h14, 16'hA044);
	endtask
	// read-clear counter and wrap past the top count
	task automatic t_crc();
		pulses(3, 1'b1);
		rdc(5'h12, 16'h8003);
		rdc(5'h12, 16'h0000);
		pulses(10001, 1'b1);
		rdc(5'h12, 16'h8001);
	endtask
	// every crossover code, reserved bits other than bit 0 stay zero
	task automatic t_mode();
		logic [15:0] w;
		logic [15:0] x;
		for (int c = 0; c < 4; c++) begin
			w = {4'hA, 1'b0, 6'h3F, 1'b1, c[1:0], 2'h3};
			wr(5'h13, w);
			rdc(5'h13, w & 16'hF81D);
			x = {8'h00, led_serial_mode_out, fast_link_fail_en_out, auto_mdix_out,
				force_mdi_out, force_mdix_out};
			chk(x, {8'h00, 4'hA, 1'b1, c < 2, c == 2, c == 3});
		end
	endtask
	// blink after hold release, then suppressed
	task automatic t_blink();
		int n;
		for (int b = 1; b >= 0; b--) begin
			wr(5'h13, {4'h0, b[0], 11'h000});
			low_power_hold_input <= 1'b1;
			repeat (8) @(posedge clk_in);
			low_power_hold_input <= 1'b0;
			waitsig(2, 40, n);
			chk({15'h0000, n < 40}, {15'h0000, b[0]});
		end
	endtask
	// every downshift count; a link-up clears partial counts
	task automatic t_ds();
		for (int c = 0; c < 4; c++) begin
			wr(5'h14, {12'hA01, c[1:0], 2'h0});
			pulses(1, 1'b0);
			link_up_in <= 1'b1;
			@(posedge clk_in);
			link_up_in <= 1'b0;
			pulses(c + 1, 1'b0);
			chk({15'h0000, downshift_out}, 16'h0000);
			pulses(1, 1'b0);
			chk({15'h0000, downshift_out}, 16'h0001);
			wr(5'h14, 16'hA004);
			chk({15'h0000, downshift_out}, 16'h0000);
		end
	endtask
	// shortest sleep and wake timers, then energy returns
	task automatic t_sleep();
		int n;
		wr(5'h14, 16'h8004);
		link_energy_in <= 1'b0;
		waitsig(0, 11000, n);
		chk({15'h0000, n > 998 * MS && n < 1002 * MS}, 16'h0001);
		if (n >= 11000) begin
			summarize();
		end
		waitsig(1, 2000, n);
		chk({15'h0000, n > 158 * MS && n < 162 * MS}, 16'h0001);
		if (n >= 2000) begin
			failures++;
			summarize();
		end
		link_energy_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		chk({15'h0000, link_sleep_out}, 16'h0000);
	endtask
	// all writable bits but 15, address swap, soft reset keeps sticky ones
	task automatic t_pwr();
		logic [15:0] x;
		wr(5'h14, 16'h7FFF);
		phy = 5'h01;
		rdc(5'h14, 16'h7E7C);
		x = {12'h000, carrier_ext_disable_out, slow_mgmt_clk_out, no_preamble_en_out,
			addr_swap_out};
		chk(x, 16'h0007);
		wr(5'h13, 16'hA01C);
		pulses(1, 1'b1);
		soft_reset_in <= 1'b1;
		@(posedge clk_in);
		soft_reset_in <= 1'b0;
		wr(5'h1F, 16'h0001);
		rdc(5'h14, 16'hFE7C);
		rdc(5'h13, 16'hA01C);
		rdc(5'h12, 16'h0000);
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		t_page();
		t_crc();
		t_mode();
		t_blink();
		t_ds();
		t_sleep();
		t_pwr();
		summarize();
	end
endmodule
`default_nettype wire
